// >>> inc/gpcf_pkg.sv
/*
 * Package for the port C to F general-purpose I/O block: register offsets, widths and reset values.
 * Assumes a core that issues single-cycle register reads and writes in I/O or data space.
 */
package gpcf_pkg;
	localparam int PORT_W = 8;
	localparam int ADDR_W = 16;
	// Short I/O space window and its data-space shift
	localparam logic [ADDR_W-1:0] IO_LAST = 16'h003F;
	localparam logic [ADDR_W-1:0] IO_DATA_BASE = 16'h0020;
	localparam logic [ADDR_W-1:0] EXT_BASE = 16'h0060;
	// Register offsets
	localparam logic [ADDR_W-1:0] OFF_F_PIN = 16'h0000;
	localparam logic [ADDR_W-1:0] OFF_E_PIN = 16'h0001;
	localparam logic [ADDR_W-1:0] OFF_E_DIR = 16'h0002;
	localparam logic [ADDR_W-1:0] OFF_E_OUT = 16'h0003;
	localparam logic [ADDR_W-1:0] OFF_D_PIN = 16'h0010;
	localparam logic [ADDR_W-1:0] OFF_D_DIR = 16'h0011;
	localparam logic [ADDR_W-1:0] OFF_D_OUT = 16'h0012;
	localparam logic [ADDR_W-1:0] OFF_C_PIN = 16'h0013;
	localparam logic [ADDR_W-1:0] OFF_F_DIR = 16'h0061;
	localparam logic [ADDR_W-1:0] OFF_F_OUT = 16'h0062;
	// Reset values
	localparam logic [PORT_W-1:0] RST_OUT = 8'h00;
	localparam logic [PORT_W-1:0] RST_DIR = 8'h00;
	localparam logic [PORT_W-1:0] RST_C_DIR_LEGACY = 8'hFF;
	localparam logic [PORT_W-1:0] ALL_ONES = 8'hFF;
	localparam logic [PORT_W-1:0] ALL_ZEROS = 8'h00;
	// Access space selector
	typedef enum logic [1:0] {
		GPCF_SP_IO = 2'b01,
		GPCF_SP_DATA = 2'b10
	} gpcf_space_t;
endpackage : gpcf_pkg

// >>> rtl/gpcf_sync.sv
/*
 * Two-stage synchroniser for one port's pin levels.
 * Assumes pin levels may change at any time relative to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module gpcf_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Pins
	input wire logic [gpcf_pkg::PORT_W-1:0] pin_raw,
	output logic [gpcf_pkg::PORT_W-1:0] pin_level
);
	import gpcf_pkg::*;
	logic [PORT_W-1:0] stage1;
	always_ff @(posedge clk) begin
		if (srst) begin
			stage1 <= ALL_ZEROS;
			pin_level <= ALL_ZEROS;
		end else begin
			stage1 <= pin_raw;
			pin_level <= stage1;
		end
	end
endmodule : gpcf_sync
`default_nettype wire

// >>> rtl/gpcf_pad.sv
/*
 * Pad control for one port: output value, output enable and pull-up.
 * Assumes pads with active-low output enable and a separate pull-up enable.
 */
`timescale 1ns/1ps
`default_nettype none
module gpcf_pad (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Port registers
	input wire logic [gpcf_pkg::PORT_W-1:0] out_data,
	input wire logic [gpcf_pkg::PORT_W-1:0] direction,
	input wire logic pullup_off,
	input wire logic input_only,
	// Pads
	output logic [gpcf_pkg::PORT_W-1:0] pad_out,
	output logic [gpcf_pkg::PORT_W-1:0] pad_oe_n,
	output logic [gpcf_pkg::PORT_W-1:0] pad_pullup
);
	import gpcf_pkg::*;
	always_ff @(posedge clk) begin
		if (srst) begin
			pad_out <= ALL_ZEROS;
			pad_oe_n <= ALL_ONES;
			pad_pullup <= ALL_ZEROS;
		end else if (input_only) begin
			pad_out <= ALL_ZEROS;
			pad_oe_n <= ALL_ONES;
			pad_pullup <= ALL_ZEROS;
		end else begin
			pad_out <= out_data;
			pad_oe_n <= ~direction;
			pad_pullup <= pullup_off ? ALL_ZEROS : (~direction & out_data);
		end
	end
endmodule : gpcf_pad
`default_nettype wire

// >>> rtl/gpcf_ports.sv
/*
 * General-purpose I/O ports C to F: pin-level registers, data and direction registers for D to F, with pad control.
 * Assumes a core issuing single-cycle accesses, tagged as short I/O space or data space.
 */
// Overview of operation
// - Short I/O accesses decode port registers at offsets 0x00 to 0x3F.
// - Data-space accesses reach low I/O registers at offset plus 0x20.
// - Extended registers from data address 0x60 answer only data-space accesses.
// - Legacy mode resets port C to push-pull outputs driving zero.
// - Legacy port C low state is reloaded from legacy_mode on every clock, not only at reset.
// - Legacy mode removes port F data and direction; port F input only.
// - Ports D, E, F data registers are 8-bit read/write, reset 0x00.
// - Ports D, E, F direction registers are 8-bit read/write, reset zero.
// - Pin level registers for C to F are read-only and ignore writes.
// - Port C levels 0x13; D at 0x12/0x11/0x10; E at 0x03/0x02/0x01.
// - Port F data 0x62 and direction 0x61 extended; F levels at 0x00.
// - Input with data set enables pull-up unless globally disabled.
`timescale 1ns/1ps
`default_nettype none
module gpcf_ports (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Mode controls
	input wire logic legacy_mode,
	input wire logic global_pullup_disable,
	// Register access
	input wire gpcf_pkg::gpcf_space_t acc_space,
	input wire logic [gpcf_pkg::ADDR_W-1:0] acc_addr,
	input wire logic acc_wr,
	input wire logic acc_rd,
	input wire logic [gpcf_pkg::PORT_W-1:0] acc_wdata,
	output logic [gpcf_pkg::PORT_W-1:0] acc_rdata,
	output logic acc_hit,
	// Port C pads
	input wire logic [gpcf_pkg::PORT_W-1:0] port_c_pin_in,
	output logic [gpcf_pkg::PORT_W-1:0] port_c_pin_out,
	output logic [gpcf_pkg::PORT_W-1:0] port_c_pin_oe_n,
	// Port D pads
	input wire logic [gpcf_pkg::PORT_W-1:0] port_d_pin_in,
	output logic [gpcf_pkg::PORT_W-1:0] port_d_pin_out,
	output logic [gpcf_pkg::PORT_W-1:0] port_d_pin_oe_n,
	output logic [gpcf_pkg::PORT_W-1:0] port_d_pullup,
	// Port E pads
	input wire logic [gpcf_pkg::PORT_W-1:0] port_e_pin_in,
	output logic [gpcf_pkg::PORT_W-1:0] port_e_pin_out,
	output logic [gpcf_pkg::PORT_W-1:0] port_e_pin_oe_n,
	output logic [gpcf_pkg::PORT_W-1:0] port_e_pullup,
	// Port F pads
	input wire logic [gpcf_pkg::PORT_W-1:0] port_f_pin_in,
	output logic [gpcf_pkg::PORT_W-1:0] port_f_pin_out,
	output logic [gpcf_pkg::PORT_W-1:0] port_f_pin_oe_n,
	output logic [gpcf_pkg::PORT_W-1:0] port_f_pullup
);
	import gpcf_pkg::*;

	typedef enum logic [3:0] {
		GPCF_R_NONE = 4'd0,
		GPCF_R_F_PIN = 4'd1,
		GPCF_R_E_PIN = 4'd2,
		GPCF_R_E_DIR = 4'd3,
		GPCF_R_E_OUT = 4'd4,
		GPCF_R_D_PIN = 4'd5,
		GPCF_R_D_DIR = 4'd6,
		GPCF_R_D_OUT = 4'd7,
		GPCF_R_C_PIN = 4'd8,
		GPCF_R_F_DIR = 4'd9,
		GPCF_R_F_OUT = 4'd10
	} gpcf_reg_t;

	// Maps a low I/O offset to its register
	function automatic gpcf_reg_t gpcf_low_reg(
		input logic [ADDR_W-1:0] off
	);
		gpcf_reg_t r;
		r = GPCF_R_NONE;
		unique case (off)
			OFF_F_PIN: r = GPCF_R_F_PIN;
			OFF_E_PIN: r = GPCF_R_E_PIN;
			OFF_E_DIR: r = GPCF_R_E_DIR;
			OFF_E_OUT: r = GPCF_R_E_OUT;
			OFF_D_PIN: r = GPCF_R_D_PIN;
			OFF_D_DIR: r = GPCF_R_D_DIR;
			OFF_D_OUT: r = GPCF_R_D_OUT;
			OFF_C_PIN: r = GPCF_R_C_PIN;
			default: r = GPCF_R_NONE;
		endcase
		return r;
	endfunction : gpcf_low_reg

	// Maps an extended data address to its register; none in legacy mode
	function automatic gpcf_reg_t gpcf_ext_reg(
		input logic [ADDR_W-1:0] a,
		input logic legacy
	);
		gpcf_reg_t r;
		r = GPCF_R_NONE;
		if (!legacy && a == OFF_F_DIR) begin
			r = GPCF_R_F_DIR;
		end else if (!legacy && a == OFF_F_OUT) begin
			r = GPCF_R_F_OUT;
		end
		return r;
	endfunction : gpcf_ext_reg

	// Maps an access to its register
	function automatic gpcf_reg_t gpcf_decode(
		input gpcf_space_t sp,
		input logic [ADDR_W-1:0] a,
		input logic legacy
	);
		gpcf_reg_t r;
		r = GPCF_R_NONE;
		if (sp == GPCF_SP_IO && a <= IO_LAST) begin
			r = gpcf_low_reg(a);
		end else if (sp == GPCF_SP_DATA && a >= IO_DATA_BASE && a <= IO_DATA_BASE + IO_LAST) begin
			r = gpcf_low_reg(a - IO_DATA_BASE);
		end else if (sp == GPCF_SP_DATA) begin
			r = gpcf_ext_reg(a, legacy);
		end
		return r;
	endfunction : gpcf_decode

	// Write strobe aimed at one register
	function automatic logic gpcf_wr_to(input gpcf_reg_t target, input gpcf_reg_t cur, input logic we);
		return we && cur == target;
	endfunction : gpcf_wr_to

	// Register select
	gpcf_reg_t sel;
	logic wr_en;

	// Port registers
	logic [PORT_W-1:0] port_d_output_data;
	logic [PORT_W-1:0] port_d_direction;
	logic [PORT_W-1:0] port_e_output_data;
	logic [PORT_W-1:0] port_e_direction;
	logic [PORT_W-1:0] port_f_output_data;
	logic [PORT_W-1:0] port_f_direction;

	// Synchronised pin levels
	logic [PORT_W-1:0] port_c_pin_levels;
	logic [PORT_W-1:0] port_d_pin_levels;
	logic [PORT_W-1:0] port_e_pin_levels;
	logic [PORT_W-1:0] port_f_pin_levels;

	// Read path
	logic [PORT_W-1:0] next_rdata;
	logic next_hit;

	// Decode of the current access
	assign sel = gpcf_decode(acc_space, acc_addr, legacy_mode);

	// Writes are dropped while reset is asserted
	assign wr_en = acc_wr && !srst;

	// Port D data register
	always_ff @(posedge clk) begin
		if (srst) begin
			port_d_output_data <= RST_OUT;
		end else if (gpcf_wr_to(GPCF_R_D_OUT, sel, wr_en)) begin
			port_d_output_data <= acc_wdata;
		end
	end

	// Port D direction register
	always_ff @(posedge clk) begin
		if (srst) begin
			port_d_direction <= RST_DIR;
		end else if (gpcf_wr_to(GPCF_R_D_DIR, sel, wr_en)) begin
			port_d_direction <= acc_wdata;
		end
	end

	// Port E data register
	always_ff @(posedge clk) begin
		if (srst) begin
			port_e_output_data <= RST_OUT;
		end else if (gpcf_wr_to(GPCF_R_E_OUT, sel, wr_en)) begin
			port_e_output_data <= acc_wdata;
		end
	end

	// Port E direction register
	always_ff @(posedge clk) begin
		if (srst) begin
			port_e_direction <= RST_DIR;
		end else if (gpcf_wr_to(GPCF_R_E_DIR, sel, wr_en)) begin
			port_e_direction <= acc_wdata;
		end
	end

	// Port F data register, held at reset value in legacy mode
	always_ff @(posedge clk) begin
		if (srst || legacy_mode) begin
			port_f_output_data <= RST_OUT;
		end else if (gpcf_wr_to(GPCF_R_F_OUT, sel, wr_en)) begin
			port_f_output_data <= acc_wdata;
		end
	end

	// Port F direction register, held at reset value in legacy mode
	always_ff @(posedge clk) begin
		if (srst || legacy_mode) begin
			port_f_direction <= RST_DIR;
		end else if (gpcf_wr_to(GPCF_R_F_DIR, sel, wr_en)) begin
			port_f_direction <= acc_wdata;
		end
	end

	// Port C output value: no data register here, always zero
	always_ff @(posedge clk) begin
		if (srst) begin
			port_c_pin_out <= ALL_ZEROS;
		end else begin
			port_c_pin_out <= ALL_ZEROS;
		end
	end

	// Port C enable: legacy mode drives from reset onward
	always_ff @(posedge clk) begin
		if (srst) begin
			port_c_pin_oe_n <= legacy_mode ? ALL_ZEROS : ALL_ONES;
		end else begin
			port_c_pin_oe_n <= legacy_mode ? ALL_ZEROS : ALL_ONES;
		end
	end

	// Port C pin synchroniser
	gpcf_sync u_sync_c (
		.clk(clk),
		.srst(srst),
		.pin_raw(port_c_pin_in),
		.pin_level(port_c_pin_levels)
	);

	// Port D pin synchroniser
	gpcf_sync u_sync_d (
		.clk(clk),
		.srst(srst),
		.pin_raw(port_d_pin_in),
		.pin_level(port_d_pin_levels)
	);

	// Port E pin synchroniser
	gpcf_sync u_sync_e (
		.clk(clk),
		.srst(srst),
		.pin_raw(port_e_pin_in),
		.pin_level(port_e_pin_levels)
	);

	// Port F pin synchroniser
	gpcf_sync u_sync_f (
		.clk(clk),
		.srst(srst),
		.pin_raw(port_f_pin_in),
		.pin_level(port_f_pin_levels)
	);

	// Port D pad driver
	gpcf_pad u_pad_d (
		.clk(clk),
		.srst(srst),
		.out_data(port_d_output_data),
		.direction(port_d_direction),
		.pullup_off(global_pullup_disable),
		.input_only(1'b0),
		.pad_out(port_d_pin_out),
		.pad_oe_n(port_d_pin_oe_n),
		.pad_pullup(port_d_pullup)
	);

	// Port E pad driver
	gpcf_pad u_pad_e (
		.clk(clk),
		.srst(srst),
		.out_data(port_e_output_data),
		.direction(port_e_direction),
		.pullup_off(global_pullup_disable),
		.input_only(1'b0),
		.pad_out(port_e_pin_out),
		.pad_oe_n(port_e_pin_oe_n),
		.pad_pullup(port_e_pullup)
	);

	// Port F pad driver, input only in legacy mode
	gpcf_pad u_pad_f (
		.clk(clk),
		.srst(srst),
		.out_data(port_f_output_data),
		.direction(port_f_direction),
		.pullup_off(global_pullup_disable),
		.input_only(legacy_mode),
		.pad_out(port_f_pin_out),
		.pad_oe_n(port_f_pin_oe_n),
		.pad_pullup(port_f_pullup)
	);

	// Read mux; pin level registers have no write path
	always_comb begin
		next_rdata = ALL_ZEROS;
		unique case (sel)
			GPCF_R_F_PIN: next_rdata = port_f_pin_levels;
			GPCF_R_E_PIN: next_rdata = port_e_pin_levels;
			GPCF_R_E_DIR: next_rdata = port_e_direction;
			GPCF_R_E_OUT: next_rdata = port_e_output_data;
			GPCF_R_D_PIN: next_rdata = port_d_pin_levels;
			GPCF_R_D_DIR: next_rdata = port_d_direction;
			GPCF_R_D_OUT: next_rdata = port_d_output_data;
			GPCF_R_C_PIN: next_rdata = port_c_pin_levels;
			GPCF_R_F_DIR: next_rdata = port_f_direction;
			GPCF_R_F_OUT: next_rdata = port_f_output_data;
			GPCF_R_NONE: next_rdata = ALL_ZEROS;
		endcase
	end

	// Any access that reaches a mapped register
	assign next_hit = (acc_rd || acc_wr) && sel != GPCF_R_NONE;

	// Registered read data
	always_ff @(posedge clk) begin
		if (srst) begin
			acc_rdata <= ALL_ZEROS;
		end else begin
			acc_rdata <= acc_rd ? next_rdata : ALL_ZEROS;
		end
	end

	// Registered hit flag
	always_ff @(posedge clk) begin
		if (srst) begin
			acc_hit <= 1'b0;
		end else begin
			acc_hit <= next_hit;
		end
	end
endmodule : gpcf_ports
`default_nettype wire

// >>> verification/gpcf_checker.sv
/*
 * Checker for the port C to F block: access decode, pad and legacy relations.
 * Assumes it is bound to gpcf_ports and runs in its single clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module gpcf_checker
	import gpcf_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Mode controls
	input wire logic legacy_mode,
	input wire logic global_pullup_disable,
	// Register access
	input wire gpcf_pkg::gpcf_space_t acc_space,
	input wire logic [15:0] acc_addr,
	input wire logic acc_wr,
	input wire logic acc_rd,
	input wire logic [7:0] acc_wdata,
	input wire logic [7:0] acc_rdata,
	input wire logic acc_hit,
	// Pads
	input wire logic [7:0] port_c_pin_out,
	input wire logic [7:0] port_c_pin_oe_n,
	input wire logic [7:0] port_d_pin_oe_n,
	input wire logic [7:0] port_d_pullup,
	input wire logic [7:0] port_e_pullup,
	input wire logic [7:0] port_f_pin_oe_n,
	input wire logic [7:0] port_f_pullup
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	dir_to_oe_a: assert property (acc_wr && acc_space == GPCF_SP_IO && acc_addr == OFF_D_DIR
		|-> ##2 port_d_pin_oe_n == ~$past(acc_wdata, 2)) else $error("port D enable mismatch");
	pin_ro_a: assert property (acc_wr && acc_space == GPCF_SP_IO && acc_addr == OFF_D_PIN && !$past(acc_wr)
		|-> ##2 port_d_pin_oe_n == $past(port_d_pin_oe_n, 2)) else $error("pin register write took effect");
	pullup_drive_a: assert property ((port_d_pullup & ~port_d_pin_oe_n) == 8'h00)
		else $error("pull-up on a driven pin");
	pullup_off_a: assert property (global_pullup_disable [*3] |-> port_e_pullup == 8'h00)
		else $error("pull-up while disabled");
	legacy_c_a: assert property (legacy_mode && $past(legacy_mode)
		|-> port_c_pin_oe_n == 8'h00 && port_c_pin_out == 8'h00) else $error("legacy port C not driving low");
	legacy_f_a: assert property (legacy_mode && $past(legacy_mode)
		|-> port_f_pin_oe_n == 8'hFF && port_f_pullup == 8'h00) else $error("legacy port F not input only");
	ext_io_a: assert property (acc_rd && acc_space == GPCF_SP_IO && acc_addr == OFF_F_OUT
		|=> !acc_hit && acc_rdata == 8'h00) else $error("extended register answered in I/O space");
	unmap_a: assert property (acc_rd && !(acc_space inside {GPCF_SP_IO, GPCF_SP_DATA})
		|=> !acc_hit && acc_rdata == 8'h00) else $error("unknown space answered");
	low_data_a: assert property (acc_rd && acc_space == GPCF_SP_DATA && acc_addr == OFF_D_PIN + IO_DATA_BASE
		|=> acc_hit) else $error("data-space alias missed");
endmodule : gpcf_checker
bind gpcf_ports gpcf_checker u_chk (.*);
`default_nettype wire

// >>> verification/gpcf_board.sv
/*
 * Board-side model of one port: pad drive, pull-up and an external source level.
 * Assumes active-low output enable; pull-up reads as one on undriven pins.
 */
`timescale 1ns/1ps
`default_nettype none
module gpcf_board (
	// Pads
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe_n,
	input wire logic [7:0] pad_pullup,
	// Board source and pin level
	input wire logic [7:0] ext_level,
	output logic [7:0] pin
);
	assign pin = (~pad_oe_n & pad_out) | (pad_oe_n & (pad_pullup | ext_level));
endmodule : gpcf_board
`default_nettype wire

// >>> verification/tb.sv
/*
 * Testbench for the port C to F block with board models on every port.
 * Assumes the 250 MHz clock and synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import gpcf_pkg::*;
	logic clk, srst, legacy_mode, global_pullup_disable, acc_wr, acc_rd, acc_hit, hv;
	gpcf_space_t acc_space;
	logic [15:0] acc_addr;
	logic [7:0] acc_wdata, acc_rdata, rv, ext;
	logic [7:0] c_in, c_out, c_oe, d_in, d_out, d_oe, d_pu, e_in, e_out, e_oe, e_pu, f_in, f_out, f_oe, f_pu;
	int n_errors = 0;
	int checks = 0;
	logic [15:0] regs [6] = '{OFF_D_DIR, OFF_D_OUT, OFF_E_DIR, OFF_E_OUT, OFF_F_DIR, OFF_F_OUT};
	logic [7:0] vals [6] = '{8'h0F, 8'hA5, 8'hF0, 8'h5A, 8'h3C, 8'hC3};
	logic [15:0] pins [3] = '{OFF_D_PIN, OFF_E_PIN, OFF_F_PIN};
	gpcf_ports u_dut (.clk(clk), .srst(srst), .legacy_mode(legacy_mode),
		.global_pullup_disable(global_pullup_disable), .acc_space(acc_space), .acc_addr(acc_addr),
		.acc_wr(acc_wr), .acc_rd(acc_rd), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_hit(acc_hit),
		.port_c_pin_in(c_in), .port_c_pin_out(c_out), .port_c_pin_oe_n(c_oe),
		.port_d_pin_in(d_in), .port_d_pin_out(d_out), .port_d_pin_oe_n(d_oe), .port_d_pullup(d_pu),
		.port_e_pin_in(e_in), .port_e_pin_out(e_out), .port_e_pin_oe_n(e_oe), .port_e_pullup(e_pu),
		.port_f_pin_in(f_in), .port_f_pin_out(f_out), .port_f_pin_oe_n(f_oe), .port_f_pullup(f_pu));
	gpcf_board u_bc (.pad_out(c_out), .pad_oe_n(c_oe), .pad_pullup(8'h00), .ext_level(ext), .pin(c_in));
	gpcf_board u_bd (.pad_out(d_out), .pad_oe_n(d_oe), .pad_pullup(d_pu), .ext_level(ext), .pin(d_in));
	gpcf_board u_be (.pad_out(e_out), .pad_oe_n(e_oe), .pad_pullup(e_pu), .ext_level(ext), .pin(e_in));
	gpcf_board u_bf (.pad_out(f_out), .pad_oe_n(f_oe), .pad_pullup(f_pu), .ext_level(ext), .pin(f_in));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic stop_test;
		if (n_errors == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input gpcf_space_t sp, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		acc_wr <= 1'b1;
		acc_space <= sp;
		acc_addr <= a;
		acc_wdata <= d;
		@(posedge clk);
		acc_wr <= 1'b0;
	endtask : wr
	task automatic rd(input gpcf_space_t sp, input logic [15:0] a);
		@(posedge clk);
		acc_rd <= 1'b1;
		acc_space <= sp;
		acc_addr <= a;
		@(posedge clk);
		acc_rd <= 1'b0;
		#1;
		rv = acc_rdata;
		hv = acc_hit;
	endtask : rd
	function automatic logic [7:0] exp_pin(input logic [7:0] d, input logic [7:0] o, input logic g);
		return (d & o) | (~d & ((o & {8{!g}}) | ext));
	endfunction : exp_pin
	task automatic do_reset;
		@(posedge clk);
		srst <= 1'b1;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
	endtask : do_reset
	task automatic t_regs;
		logic [15:0] da;
		for (int i = 0; i < 6; i++) begin
			da = regs[i] < EXT_BASE ? regs[i] + IO_DATA_BASE : regs[i];
			rd(GPCF_SP_DATA, da);
			chk("reset value", rv, 8'h00);
			wr(i < 4 ? GPCF_SP_IO : GPCF_SP_DATA, regs[i], vals[i]);
			rd(GPCF_SP_DATA, da);
			chk("readback", rv, vals[i]);
			chk("hit", {7'h00, hv}, 8'h01);
			if (i >= 4) begin
				rd(GPCF_SP_IO, regs[i]);
				chk("extended via io", {7'h00, hv}, 8'h00);
			end
		end
	endtask : t_regs
	task automatic t_pins;
		for (int g = 0; g < 2; g++) begin
			@(posedge clk);
			global_pullup_disable <= g[0];
			ext <= g[0] ? 8'h96 : 8'h00;
			repeat (4) @(posedge clk);
			#1;
			chk("pullup d", d_pu, ~vals[0] & vals[1] & {8{!g[0]}});
			chk("enable e", e_oe, ~vals[2]);
			for (int p = 0; p < 3; p++) begin
				rd(GPCF_SP_DATA, pins[p] + IO_DATA_BASE);
				chk("pin level", rv, exp_pin(vals[2 * p], vals[2 * p + 1], g[0]));
			end
			rd(GPCF_SP_IO, OFF_C_PIN);
			chk("pin level c", rv, ext);
		end
	endtask : t_pins
	task automatic t_refuse;
		wr(GPCF_SP_IO, OFF_D_PIN, 8'hFF);
		rd(GPCF_SP_IO, OFF_D_DIR);
		chk("direction d", rv, vals[0]);
		rd(GPCF_SP_IO, 16'h0005);
		chk("unmapped hit", {7'h00, hv}, 8'h00);
		rd(gpcf_space_t'(2'b00), OFF_D_DIR);
		chk("no space", rv, 8'h00);
	endtask : t_refuse
	task automatic t_legacy;
		@(posedge clk);
		legacy_mode <= 1'b1;
		do_reset;
		wr(GPCF_SP_DATA, OFF_F_DIR, 8'hFF);
		rd(GPCF_SP_DATA, OFF_F_DIR);
		chk("legacy f hit", {7'h00, hv}, 8'h00);
		rd(GPCF_SP_IO, OFF_F_PIN);
		chk("legacy f pin", rv, ext);
		chk("legacy f enable", f_oe, 8'hFF);
		chk("legacy c enable", c_oe, 8'h00);
		chk("legacy c out", c_out, 8'h00);
	endtask : t_legacy
	initial begin
		srst = 1'b1;
		legacy_mode = 1'b0;
		global_pullup_disable = 1'b0;
		acc_wr = 1'b0;
		acc_rd = 1'b0;
		acc_space = GPCF_SP_IO;
		acc_addr = 16'h0000;
		acc_wdata = 8'h00;
		ext = 8'h00;
		do_reset;
		t_regs;
		t_pins;
		t_refuse;
		t_legacy;
		stop_test;
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		stop_test;
	end
endmodule : tb
`default_nettype wire
